// *** hdl/pra_pkg.sv ***
// shared constants and types of the packet ram access arbiter
package pra_pkg;
   // widths of the memory side and of the host byte fifo
   localparam int PTR_W      = 11;
   localparam int PNUM_W     = 6;
   localparam int DATA_W     = 16;
   localparam int BYTE_W     = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W      = 5;
   // fifo levels that steer prefetch, drain and host ready
   localparam logic [CNT_W-1:0] LVL_EMPTY    = 5'h00;
   localparam logic [CNT_W-1:0] LVL_REFILL   = 5'h01;
   localparam logic [CNT_W-1:0] LVL_WORD     = 5'h02;
   localparam logic [CNT_W-1:0] LVL_WR_MAX   = 5'h0e;
   // pointer steps for byte and word memory cycles
   localparam logic [PTR_W-1:0] STEP_BYTE = 11'h001;
   localparam logic [PTR_W-1:0] STEP_WORD = 11'h002;
   // host path direction, memory cycle state and cycle owner
   typedef enum logic {DIR_WR, DIR_RD} pra_dir_e;
   typedef enum logic {MEM_IDLE, MEM_BUSY} pra_mem_e;
   typedef enum logic [1:0] {SRC_HOST, SRC_RX, SRC_TX} pra_src_e;
endpackage

// *** hdl/pra_arb_if.sv ***
// request and grant signals between the access engine and the arbiter
`timescale 1ns/10ps
interface pra_arb_if;
   logic host_req;
   logic rx_req;
   logic tx_req;
   logic full_duplex;
   logic take;
   logic gnt_host;
   logic gnt_rx;
   logic gnt_tx;
   modport client (
      output host_req,
      output rx_req,
      output tx_req,
      output full_duplex,
      output take,
      input  gnt_host,
      input  gnt_rx,
      input  gnt_tx
   );
   modport arbiter (
      input  host_req,
      input  rx_req,
      input  tx_req,
      input  full_duplex,
      input  take,
      output gnt_host,
      output gnt_rx,
      output gnt_tx
   );
endinterface

// *** hdl/pra_fifo.sv ***
// byte fifo taking and giving one or two bytes per cycle
`timescale 1ns/10ps
module pra_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       reset_n,
   input  wire logic                       flush,
   // filling side
   input  wire logic                       in_valid,
   input  wire logic                       in_two,
   input  wire logic [2*WIDTH-1:0]         in_data,
   output logic                            in_ready,
   // draining side
   output logic                            out_valid,
   input  wire logic                       out_ready,
   input  wire logic                       out_two,
   output logic [2*WIDTH-1:0]              out_data,
   // fill level now and after this cycle
   output logic [$clog2(DEPTH):0]          level,
   output logic [$clog2(DEPTH):0]          level_next
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] ONE  = CW'(1);
   localparam logic [CW-1:0] TWO  = CW'(2);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0]    wr_idx;
   logic [AW-1:0]    rd_idx;
   logic [CW-1:0]    push_n;
   logic [CW-1:0]    pop_n;
   wire  [AW-1:0]    wr_idx_hi = wr_idx + AW'(1);
   wire  [AW-1:0]    rd_idx_hi = rd_idx + AW'(1);

   // space for a whole word is needed before a push is taken
   assign in_ready   = (FULL - level) >= TWO;
   assign out_valid  = level != '0;
   assign push_n     = (in_valid && in_ready) ? (in_two ? TWO : ONE) : '0;
   assign pop_n      = (out_valid && out_ready) ?
                       ((out_two && level >= TWO) ? TWO : ONE) : '0;
   assign level_next = flush ? '0 : level + push_n - pop_n;
   assign out_data   = {store[rd_idx_hi], store[rd_idx]};

   // per entry storage, low lane at the write index, high lane after it
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      wire lo_hit = push_n != '0 && wr_idx == AW'(i);
      wire hi_hit = push_n == TWO && wr_idx_hi == AW'(i);
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            store[i] <= '0;
         end else if (lo_hit) begin
            store[i] <= in_data[WIDTH-1:0];
         end else if (hi_hit) begin
            store[i] <= in_data[2*WIDTH-1:WIDTH];
         end
      end
   end

   // pointers and level; flush empties the fifo at once
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_idx <= '0;
         rd_idx <= '0;
         level  <= '0;
      end else begin
         wr_idx <= flush ? '0 : wr_idx + push_n[AW-1:0];
         rd_idx <= flush ? '0 : rd_idx + pop_n[AW-1:0];
         level  <= level_next;
      end
   end
endmodule

// *** hdl/pra_grant.sv ***
// memory arbiter between host fifo and mac receive and transmit dma
`timescale 1ns/10ps
module pra_grant
   import pra_pkg::*;
(
   // clock and reset
   input  wire logic  sys_clk,
   input  wire logic  reset_n,
   // requests and grants
   pra_arb_if.arbiter arb
);
   logic last_mac;
   logic last_rx;
   wire  mac_any  = arb.rx_req || arb.tx_req;
   // full duplex takes turns between rx and tx, else rx goes first
   wire  rx_pick  = arb.rx_req &&
                    !(arb.tx_req && arb.full_duplex && last_rx);

   // host and mac take turns so the host slot comes round evenly
   assign arb.gnt_host = arb.host_req && (!mac_any || last_mac);
   assign arb.gnt_rx   = !arb.gnt_host && rx_pick;
   assign arb.gnt_tx   = !arb.gnt_host && !rx_pick && arb.tx_req;

   // remember the owner of the last cycle taken
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         last_mac <= 1'b0;
         last_rx  <= 1'b0;
      end else if (arb.take && (arb.gnt_host || mac_any)) begin
         last_mac <= !arb.gnt_host;
         if (!arb.gnt_host) begin
            last_rx <= arb.gnt_rx;
         end
      end
   end
endmodule

// *** hdl/pra_arbiter.sv ***
// packet ram access arbiter with host byte fifo and mac dma routing
`timescale 1ns/10ps
module pra_arbiter
   import pra_pkg::*;
(
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                reset_n,
   // host data register side, from bus logic on sys_clk
   input  wire logic                host_load,
   input  wire logic [PTR_W-1:0]    host_load_addr,
   input  wire logic                host_load_rd,
   input  wire logic [PNUM_W-1:0]   host_pnum,
   input  wire logic                host_wr,
   input  wire logic                host_wr_word,
   input  wire logic [DATA_W-1:0]   host_wr_data,
   input  wire logic                host_rd,
   input  wire logic                host_rd_word,
   output logic [DATA_W-1:0]        host_rd_data,
   output logic                     host_ready,
   // mac dma side
   input  wire logic                full_duplex,
   input  wire logic                mac_rx_req,
   input  wire logic [PTR_W-1:0]    mac_rx_addr,
   input  wire logic [PNUM_W-1:0]   mac_rx_pnum,
   input  wire logic [DATA_W-1:0]   mac_rx_data,
   input  wire logic                mac_tx_req,
   input  wire logic [PTR_W-1:0]    mac_tx_addr,
   input  wire logic [PNUM_W-1:0]   mac_tx_pnum,
   output logic                     mac_rx_done,
   output logic                     mac_tx_done,
   output logic [DATA_W-1:0]        mac_tx_data,
   // packet memory and mmu side
   output logic                     mem_cyc,
   output logic                     mem_we,
   output logic                     mem_word,
   output logic [PTR_W-1:0]         mem_addr,
   output logic [PNUM_W-1:0]        mem_pnum,
   output logic [DATA_W-1:0]        mem_wdata,
   input  wire logic [DATA_W-1:0]   mem_rdata,
   input  wire logic                mem_ack
);
   pra_arb_if arb ();

   // host path state
   pra_dir_e           dir;
   logic [PTR_W-1:0]   ptr;
   logic [PNUM_W-1:0]  pnum;
   logic               pend;
   logic [PTR_W-1:0]   pend_addr;
   logic               pend_rd;
   logic [PNUM_W-1:0]  pend_pnum;
   // memory cycle state
   pra_mem_e           mem_state;
   pra_src_e           cyc_src;
   // fifo hookup
   logic               fifo_in_valid;
   logic               fifo_in_two;
   logic [DATA_W-1:0]  fifo_in_data;
   logic               fifo_in_ready;
   logic               fifo_out_valid;
   logic               fifo_out_ready;
   logic               fifo_out_two;
   logic [DATA_W-1:0]  fifo_out_data;
   logic [CNT_W-1:0]   level;
   logic [CNT_W-1:0]   level_next;
   logic               next_host_ready;

   // decode of the host path
   wire dir_wr      = dir == DIR_WR;
   wire ptr_odd     = ptr[0];
   wire mem_idle    = mem_state == MEM_IDLE;
   wire ack_now     = !mem_idle && mem_ack;
   wire ack_host    = ack_now && cyc_src == SRC_HOST;
   wire ack_rx      = ack_now && cyc_src == SRC_RX;
   wire ack_tx      = ack_now && cyc_src == SRC_TX;
   wire ack_host_wr = ack_host && mem_we;
   wire ack_host_rd = ack_host && !mem_we;

   // write drain: word only at even address with a word held
   wire wr_word = !ptr_odd && level >= LVL_WORD;
   // odd pointer always starts with a lone byte
   wire rd_word = !ptr_odd;
   wire host_word = dir_wr ? wr_word : rd_word;
   // the fifo's own not-empty flag raises the drain request
   wire wr_req  = fifo_out_valid;
   // prefetch keeps the fifo topped up to three bytes at most
   wire rd_req  = level <= LVL_REFILL && !pend;

   // a reload takes effect once writes are drained and no cycle runs
   wire apply   = pend && mem_idle &&
                  (!dir_wr || level == LVL_EMPTY);
   // every reload empties the fifo, so stale prefetched bytes never
   // reach memory as write data; a reload made in write direction applies only once
   // the fifo has drained, so no posted byte is lost
   wire fifo_flush = apply;

   // requests to the arbiter
   assign arb.host_req    = dir_wr ? wr_req : rd_req;
   assign arb.rx_req      = mac_rx_req;
   assign arb.tx_req      = mac_tx_req;
   assign arb.full_duplex = full_duplex;
   assign arb.take        = mem_idle;

   pra_grant u_grant (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .arb     (arb)
   );

   // fifo filling: host writes or prefetched memory data
   wire [BYTE_W-1:0] rd_byte = ptr_odd ? mem_rdata[DATA_W-1:BYTE_W] :
                                         mem_rdata[BYTE_W-1:0];
   // a write without room is dropped rather than overrunning the fifo
   wire host_push = host_wr && fifo_in_ready;
   assign fifo_in_valid = dir_wr ? host_push : ack_host_rd;
   assign fifo_in_two   = dir_wr ? host_wr_word : mem_word;
   assign fifo_in_data  = dir_wr ? host_wr_data :
                          (mem_word ? mem_rdata : {{BYTE_W{1'b0}}, rd_byte});

   // fifo draining: write cycle done or host read taken
   assign fifo_out_ready = dir_wr ? ack_host_wr : host_rd;
   assign fifo_out_two   = dir_wr ? mem_word : host_rd_word;

   pra_fifo #(
      .WIDTH (BYTE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .flush      (fifo_flush),
      .in_valid   (fifo_in_valid),
      .in_two     (fifo_in_two),
      .in_data    (fifo_in_data),
      .in_ready   (fifo_in_ready),
      .out_valid  (fifo_out_valid),
      .out_ready  (fifo_out_ready),
      .out_two    (fifo_out_two),
      .out_data   (fifo_out_data),
      .level      (level),
      .level_next (level_next)
   );

   // write data for the memory: a lone byte sits on both lanes
   wire [DATA_W-1:0] host_wdata = wr_word ? fifo_out_data :
      {fifo_out_data[BYTE_W-1:0], fifo_out_data[BYTE_W-1:0]};

   // host ready: writes need room, reads need a word already staged;
   // it is never pulled inside an access, only between accesses
   always_comb begin
      next_host_ready = 1'b0;
      if (!pend && !host_load && !apply) begin
         if (dir_wr) begin
            next_host_ready = level_next <= LVL_WR_MAX;
         end else begin
            next_host_ready = level >= LVL_WORD && !host_rd;
         end
      end
   end

   // host outputs: staged read data and ready
   // read data is the fifo head of the previous cycle, so it is settled
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         host_ready   <= 1'b0;
         host_rd_data <= '0;
      end else begin
         host_ready   <= next_host_ready;
         host_rd_data <= fifo_out_data;
      end
   end

   // pointer load is held until the fifo may be reused
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pend      <= 1'b0;
         pend_addr <= '0;
         pend_rd   <= 1'b0;
         pend_pnum <= '0;
      end else if (host_load) begin
         pend      <= 1'b1;
         pend_addr <= host_load_addr;
         pend_rd   <= host_load_rd;
         pend_pnum <= host_pnum;
      end else if (apply) begin
         pend      <= 1'b0;
      end
   end

   // host pointer, direction and packet number
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         dir  <= DIR_WR;
         ptr  <= '0;
         pnum <= '0;
      end else if (apply) begin
         dir  <= pend_rd ? DIR_RD : DIR_WR;
         ptr  <= pend_addr;
         pnum <= pend_pnum;
      end else if (ack_host) begin
         ptr  <= ptr + (mem_word ? STEP_WORD : STEP_BYTE);
      end
   end

   // memory cycle state: start on a grant, end on the memory ack
   // grants are ignored while busy, so one cycle runs at a time
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_state <= MEM_IDLE;
         cyc_src   <= SRC_HOST;
      end else begin
         case (mem_state)
            MEM_IDLE: begin
               if (arb.gnt_host) begin
                  mem_state <= MEM_BUSY;
                  cyc_src   <= SRC_HOST;
               end else if (arb.gnt_rx) begin
                  mem_state <= MEM_BUSY;
                  cyc_src   <= SRC_RX;
               end else if (arb.gnt_tx) begin
                  mem_state <= MEM_BUSY;
                  cyc_src   <= SRC_TX;
               end
            end
            MEM_BUSY: begin
               if (mem_ack) begin
                  mem_state <= MEM_IDLE;
               end
            end
            default: begin
               mem_state <= MEM_IDLE;
            end
         endcase
      end
   end

   // memory and mmu outputs, routed from the granted source
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_cyc   <= 1'b0;
         mem_we    <= 1'b0;
         mem_word  <= 1'b0;
         mem_addr  <= '0;
         mem_pnum  <= '0;
         mem_wdata <= '0;
      end else if (mem_idle && arb.gnt_host) begin
         mem_cyc   <= 1'b1;
         mem_we    <= dir_wr;
         mem_word  <= host_word;
         mem_addr  <= ptr;
         mem_pnum  <= pnum;
         mem_wdata <= host_wdata;
      end else if (mem_idle && arb.gnt_rx) begin
         mem_cyc   <= 1'b1;
         mem_we    <= 1'b1;
         mem_word  <= 1'b1;
         mem_addr  <= mac_rx_addr;
         mem_pnum  <= mac_rx_pnum;
         mem_wdata <= mac_rx_data;
      end else if (mem_idle && arb.gnt_tx) begin
         mem_cyc   <= 1'b1;
         mem_we    <= 1'b0;
         mem_word  <= 1'b1;
         mem_addr  <= mac_tx_addr;
         mem_pnum  <= mac_tx_pnum;
      end else if (ack_now) begin
         mem_cyc   <= 1'b0;
      end
   end

   // dma completion pulses and transmit read data
   // done trails the ack by one edge; the mac drops its request then
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mac_rx_done <= 1'b0;
         mac_tx_done <= 1'b0;
         mac_tx_data <= '0;
      end else begin
         mac_rx_done <= ack_rx;
         mac_tx_done <= ack_tx;
         if (ack_tx) begin
            mac_tx_data <= mem_rdata;
         end
      end
   end
endmodule

// *** dv/pra_arbiter_asserts.sv ***
// port assertions of the packet ram access arbiter, bound into it
`timescale 1ns/10ps
module pra_arbiter_asserts
   import pra_pkg::*;
(
   // clock and reset
   input wire logic              sys_clk,
   input wire logic              reset_n,
   // host side
   input wire logic              host_load,
   input wire logic              host_load_rd,
   input wire logic              host_wr,
   input wire logic              host_rd,
   input wire logic              host_ready,
   // mac and memory side
   input wire logic              mac_rx_done,
   input wire logic              mac_tx_done,
   input wire logic [DATA_W-1:0] mac_tx_data,
   input wire logic              mem_cyc,
   input wire logic              mem_we,
   input wire logic              mem_word,
   input wire logic [PTR_W-1:0]  mem_addr,
   input wire logic [DATA_W-1:0] mem_rdata,
   input wire logic              mem_ack
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // host access timing
   a_rd_ready_gap: assert property (host_rd |=> !host_ready)
      else $error("ready held after read");
   a_load_ready_drop: assert property (host_load |=> !host_ready)
      else $error("ready held after load");
   a_rd_prefetch: assert property (
      host_load && host_load_rd |-> ##[3:120] host_ready)
      else $error("no data after read load");
   a_wr_drain_req: assert property (
      host_wr |-> ##[1:80] (mem_cyc && mem_we))
      else $error("posted write never drained");
   // memory cycle shape
   a_mem_hold: assert property (
      mem_cyc && !mem_ack |=> mem_cyc && $stable(mem_addr)
         && $stable(mem_we) && $stable(mem_word))
      else $error("memory cycle changed before ack");
   a_mem_end: assert property (mem_cyc && mem_ack |=> !mem_cyc)
      else $error("memory cycle not ended by ack");
   a_word_even: assert property (mem_cyc && mem_word |-> !mem_addr[0])
      else $error("word cycle at odd address");
   // mac completion
   a_rx_done_ack: assert property (
      mac_rx_done |-> $past(mem_cyc && mem_ack && mem_we))
      else $error("rx done without write ack");
   a_tx_data_ack: assert property (
      mac_tx_done |-> mac_tx_data == $past(mem_rdata)
         && $past(mem_cyc && mem_ack && !mem_we) ##1 !mac_tx_done)
      else $error("tx done data or pulse wrong");
endmodule

bind pra_arbiter pra_arbiter_asserts u_chk (
   .sys_clk(sys_clk), .reset_n(reset_n), .host_load(host_load),
   .host_load_rd(host_load_rd), .host_wr(host_wr), .host_rd(host_rd),
   .host_ready(host_ready), .mac_rx_done(mac_rx_done),
   .mac_tx_done(mac_tx_done), .mac_tx_data(mac_tx_data),
   .mem_cyc(mem_cyc), .mem_we(mem_we), .mem_word(mem_word),
   .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack)
);

// *** dv/pra_mem_model.sv ***
// packet memory model answering the arbiter's memory cycles
`timescale 1ns/10ps
module pra_mem_model
   import pra_pkg::*;
(
   // clock and stall length chosen by the bench
   input wire logic              sys_clk,
   input wire logic [1:0]        stall,
   // memory cycle
   input wire logic              mem_cyc,
   input wire logic              mem_we,
   input wire logic              mem_word,
   input wire logic [PTR_W-1:0]  mem_addr,
   input wire logic [DATA_W-1:0] mem_wdata,
   output logic [DATA_W-1:0]     mem_rdata,
   output logic                  mem_ack
);
   logic [BYTE_W-1:0] m [0:2047];
   logic [PTR_W-1:0]  a;
   int                w;
   // contents preset to a fixed byte pattern
   initial begin
      for (int i = 0; i < 2048; i++) m[i] = BYTE_W'(i * 7 + 3);
      mem_rdata = 16'h0000;
      mem_ack = 1'b0;
      w = 0;
   end
   // answer after the stall; read data toggles outside the answer
   always @(posedge sys_clk) begin
      a = mem_addr;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_cyc && !mem_ack) begin
         if (w < stall) w = w + 1;
         else begin
            w = 0;
            mem_ack <= 1'b1;
            if (!mem_we && mem_word) mem_rdata <= {m[a + 11'h001], m[a]};
            if (!mem_we && !mem_word) mem_rdata <= {2{m[a]}};
            if (mem_we && mem_word) m[a + 11'h001] = mem_wdata[15:8];
            if (mem_we) m[a] = a[0] ? mem_wdata[15:8] : mem_wdata[7:0];
            if (mem_we && mem_word) m[a] = mem_wdata[7:0];
         end
      end
   end
endmodule

// *** dv/tb.sv ***
// self-checking bench for the packet ram access arbiter
`timescale 1ns/10ps
module tb;
   import pra_pkg::*;
   logic              sys_clk, reset_n, host_load, host_load_rd, host_wr;
   logic              host_wr_word, host_rd, host_rd_word, host_ready;
   logic              full_duplex, mac_rx_req, mac_tx_req, mac_rx_done;
   logic              mac_tx_done, mem_cyc, mem_we, mem_word, mem_ack;
   logic              mac_mode, mon_w;
   logic [1:0]        stall;
   logic [PTR_W-1:0]  host_load_addr, mac_rx_addr, mac_tx_addr, mem_addr;
   logic [PTR_W-1:0]  ptr, mon_a, ra;
   logic [PNUM_W-1:0] host_pnum, mac_rx_pnum, mac_tx_pnum, mem_pnum;
   logic [DATA_W-1:0] host_wr_data, host_rd_data, mac_rx_data, mac_tx_data;
   logic [DATA_W-1:0] mem_wdata, mem_rdata;
   logic [BYTE_W-1:0] sh [0:2047];
   int                err_total, n_checks, seed, mon_n, last_done, k, nd;
   // design and memory partner
   pra_arbiter dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .host_load(host_load),
      .host_load_addr(host_load_addr), .host_load_rd(host_load_rd),
      .host_pnum(host_pnum), .host_wr(host_wr), .host_wr_word(host_wr_word),
      .host_wr_data(host_wr_data), .host_rd(host_rd),
      .host_rd_word(host_rd_word), .host_rd_data(host_rd_data),
      .host_ready(host_ready), .full_duplex(full_duplex),
      .mac_rx_req(mac_rx_req), .mac_rx_addr(mac_rx_addr),
      .mac_rx_pnum(mac_rx_pnum), .mac_rx_data(mac_rx_data),
      .mac_tx_req(mac_tx_req), .mac_tx_addr(mac_tx_addr),
      .mac_tx_pnum(mac_tx_pnum), .mac_rx_done(mac_rx_done),
      .mac_tx_done(mac_tx_done), .mac_tx_data(mac_tx_data),
      .mem_cyc(mem_cyc), .mem_we(mem_we), .mem_word(mem_word),
      .mem_addr(mem_addr), .mem_pnum(mem_pnum), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   pra_mem_model u_mem (
      .sys_clk(sys_clk), .stall(stall), .mem_cyc(mem_cyc), .mem_we(mem_we),
      .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   // clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic bound(input logic ok);
      if (!ok) begin
         err_total++;
         tally_and_finish();
      end
   endtask
   // pointer load, then wait for the new direction to be ready
   task automatic load(input logic [PTR_W-1:0] a, input logic rd);
      repeat (12) @(negedge sys_clk);
      host_load = 1'b1;
      host_load_addr = a;
      host_load_rd = rd;
      host_pnum = a[5:0];
      mon_a = a;
      mon_w = 1'b0;
      mon_n = a[0] ? (rd ? 2 : 1) : 0;
      ptr = a;
      @(negedge sys_clk);
      host_load = 1'b0;
      chk(host_ready, 0);
      for (k = 0; k < 300 && host_ready !== 1'b1; k++) @(negedge sys_clk);
      bound(k < 300);
   endtask
   // posted writes whenever ready, bytes and words mixed
   task automatic wr_burst(input int n);
      int i;
      i = 0;
      for (k = 0; k < 400 && i < n; k++) begin
         host_wr = host_ready;
         if (host_ready === 1'b1) begin
            host_wr_word = $random(seed);
            host_wr_data = $random(seed);
            sh[ptr] = host_wr_data[7:0];
            if (host_wr_word) sh[ptr + 11'h001] = host_wr_data[15:8];
            ptr = ptr + (host_wr_word ? 11'h002 : 11'h001);
            i++;
         end
         @(negedge sys_clk);
      end
      host_wr = 1'b0;
      bound(i == n);
   endtask
   // reads whenever ready, data compared with the shadow memory
   task automatic rd_burst(input int n);
      int i;
      i = 0;
      for (k = 0; k < 400 && i < n; k++) begin
         host_rd = host_ready;
         if (host_ready === 1'b1) begin
            host_rd_word = $random(seed);
            chk(host_rd_data[7:0], sh[ptr]);
            if (host_rd_word) chk(host_rd_data[15:8], sh[ptr + 11'h001]);
            ptr = ptr + (host_rd_word ? 11'h002 : 11'h001);
            i++;
         end
         @(negedge sys_clk);
      end
      host_rd = 1'b0;
      bound(i == n);
   endtask
   // memory cycle monitor: odd-pointer order, mac routing, mac results
   always @(posedge sys_clk) begin
      if (mem_cyc && mem_ack && mon_n > 0 && mem_we !== host_load_rd) begin
         chk({mem_word, mem_addr}, {mon_w, mon_a});
         mon_n--;
         mon_w = 1'b1;
         mon_a = mon_a + 11'h001;
      end
      if (mem_cyc && mem_ack && mac_mode) begin
         if (mem_we) chk({mem_pnum, mem_addr}, {mac_rx_pnum, mac_rx_addr});
         else chk({mem_pnum, mem_addr}, {mac_tx_pnum, mac_tx_addr});
         if (mem_we) sh[mem_addr] = mac_rx_data[7:0];
         if (mem_we) sh[mem_addr + 11'h001] = mac_rx_data[15:8];
      end
      if (mac_tx_done === 1'b1)
         chk(mac_tx_data, {sh[mac_tx_addr + 11'h001], sh[mac_tx_addr]});
      if (mac_rx_done === 1'b1 || mac_tx_done === 1'b1) begin
         if (full_duplex && last_done != 0) chk(mac_rx_done, last_done == 2);
         last_done = mac_rx_done ? 1 : 2;
      end
   end
   // main sequence
   initial begin
      seed = 32'hc52357a5;
      {reset_n, host_load, host_load_rd, host_wr, host_wr_word} = 5'h00;
      {host_rd, host_rd_word, full_duplex, mac_rx_req, mac_tx_req} = 5'h00;
      {host_load_addr, host_pnum, host_wr_data, stall} = 35'h0;
      {mac_rx_addr, mac_tx_addr, mac_rx_pnum, mac_tx_pnum} = 34'h0400a;
      {mac_rx_data, ptr, mon_a, mon_w, mac_mode} = 40'h0;
      err_total = 0;
      n_checks = 0;
      mon_n = 0;
      last_done = 0;
      for (int i = 0; i < 2048; i++) sh[i] = BYTE_W'(i * 7 + 3);
      repeat (12) @(negedge sys_clk);
      reset_n = 1'b1;
      for (int r = 0; r < 4; r++) begin
         stall = 2'(r);
         ra = (r == 0) ? 11'h010 : (r == 1) ? 11'h041 : 11'($random(seed));
         load(ra, 1'b0);
         wr_burst(16);
         load(ra, 1'b1);
         rd_burst(12);
         $display("host round %0d done", r);
      end
      repeat (12) @(negedge sys_clk);
      mac_mode = 1'b1;
      mac_rx_data = 16'($random(seed));
      {mac_rx_pnum, mac_tx_pnum} = 12'($random(seed));
      mac_rx_addr = {10'($random(seed)), 1'b0};
      mac_tx_addr = mac_rx_addr ^ 11'h400;
      mac_rx_req = 1'b1;
      for (k = 0; k < 50 && mac_rx_done !== 1'b1; k++) @(negedge sys_clk);
      bound(k < 50);
      mac_rx_req = 1'b0;
      mac_tx_req = 1'b1;
      for (k = 0; k < 50 && mac_tx_done !== 1'b1; k++) @(negedge sys_clk);
      bound(k < 50);
      mac_tx_req = 1'b0;
      @(negedge sys_clk);
      full_duplex = 1'b1;
      last_done = 0;
      {mac_rx_req, mac_tx_req} = 2'b11;
      nd = 0;
      for (k = 0; k < 200 && nd < 6; k++) begin
         @(negedge sys_clk);
         nd = nd + mac_rx_done + mac_tx_done;
      end
      bound(nd >= 6);
      {mac_rx_req, mac_tx_req} = 2'b00;
      repeat (8) @(negedge sys_clk);
      $display("mac round done");
      tally_and_finish();
   end
endmodule
